// *** verilog/vector_map_defs.svh ***
// Register offsets, field positions, vectors and timing counts of the vector map.
// Assumes a 32-bit plain register port with byte offsets that are multiples of four.
`ifndef VECTOR_MAP_DEFS_SVH
`define VECTOR_MAP_DEFS_SVH

// ==========================================================
// Register offsets
`define OFF_ENABLE_LO     8'h00
`define OFF_ENABLE_HI     8'h04
`define OFF_RAISE         8'h08
`define OFF_RESET_CTRL    8'h0c
`define OFF_RESET_CAUSE   8'h10
`define OFF_INT_STATUS    8'h14
`define OFF_INT_MASK      8'h18
`define OFF_CURRENT       8'h1c

// ==========================================================
// Fields
`define CTRL_MON_EN_BIT   0
`define CTRL_FORCE_BIT    1
`define CTRL_RATE_LSB     2
`define CTRL_RATE_MSB     4
`define CAUSE_POWER_BIT   0
`define CAUSE_PIN_BIT     1
`define CAUSE_LOWV_BIT    2
`define CAUSE_CLOCK_BIT   3
`define CAUSE_WDOG_BIT    4
`define EVT_RESERVED_BIT  0
`define EVT_WARNING_BIT   1
`define EVT_CLKBLOCK_BIT  2
`define EVT_NONMASK_BIT   3
`define EVENT_COUNT       4

// ==========================================================
// Vectors and slots
`define SLOT_COUNT        58
`define SLOT_WARNING      5
`define RESERVED_SLOTS    58'h573e0ffff1f
`define VEC_POWER         16'hfffe
`define VEC_CLOCK         16'hfffc
`define VEC_WDOG          16'hfffa
`define VEC_NONMASK       16'hfff4
`define VEC_SLOT_BASE     8'h80
`define VEC_PAGE          8'hff
`define RESET_HOLD_CYCLES 16

`endif

// *** verilog/vector_map_pkg.sv ***
// Types shared by the vector map files.
// Assumes nothing of its surroundings.
package vector_map_pkg;
  typedef enum logic [1:0] {st_run, st_hold} reset_state_type;
  typedef enum logic [1:0] {class_none, class_power, class_clock, class_wdog} reset_class_type;
endpackage

// *** verilog/bit_sync.sv ***
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes inputs arrive from outside the clk domain.
`timescale 1ns/1ns
module bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage_reg <= INIT;
      sync_out  <= INIT;
    end else begin
      stage_reg <= async_in;
      sync_out  <= stage_reg;
    end
  end
endmodule

// *** verilog/top_select.sv ***
// Finds the highest set bit of a request vector.
// Assumes a combinational use inside one clock domain.
`timescale 1ns/1ns
module top_select #(
  parameter int N  = 58,
  parameter int IW = 6
) (
  input  wire logic [N-1:0]  req,
  output logic               found,
  output logic [IW-1:0]      index
);
  function automatic logic [IW:0] highest(input logic [N-1:0] v);
    logic [IW:0] r;
    r = '0;
    for (int i = 0; i < N; i++) begin
      if (v[i]) begin
        r = {1'b1, IW'(i)};
      end
    end
    return r;
  endfunction

  always_comb begin
    {found, index} = highest(req);
  end
endmodule

// *** verilog/vector_priority_map.sv ***
// Reset and interrupt vector selection with default priority, local enables and elevation.
// Assumes peripheral requests and core mask bits on clk; reset pin and
// nonmaskable pin are asynchronous and are synchronised here.
//
// Overview of operation
// - Among pending sources the one with the higher vector address wins, unless the raise register elevates a pending slot.
// - Power-on, pin and low-voltage resets all use vector 0xFFFE with no mask or enable.
// - The cause of a shared-vector reset is kept in flags that software can read.
// - A clock-monitor failure resets through 0xFFFC only when its enable bits allow.
// - A watchdog timeout resets through 0xFFFA at level 3 only with a nonzero rate.
// - Level 1 resets beat a clock-monitor reset, which beats a watchdog reset.
// - Resets rank above every interrupt and return all control state to start values.
// - No reset clears any memory contents; only registers are initialised.
// - Timer channels 0 to 7 use 0xFFEE down to 0xFFE0, I-masked and channel-enabled.
// - Accumulator overflow uses 0xFFDC, I-masked and gated by its overflow enable.
// - Accumulator edge uses 0xFFDA, I-masked and gated by its edge enable.
// - The low-voltage warning uses 0xFF8A, I-masked and gated by its enable.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ns
`include "vector_map_defs.svh"
module vector_priority_map #(
  parameter int HOLD_CYCLES = `RESET_HOLD_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic [7:0]             addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr_strobe,
  input  wire logic                   rd_strobe,
  output logic      [31:0]            rdata,
  input  wire logic [`SLOT_COUNT-1:0] req_in,
  input  wire logic                   i_mask,
  input  wire logic                   x_mask,
  input  wire logic                   nonmaskable_request_pin,
  input  wire logic                   reset_pin_n,
  input  wire logic                   power_on_event,
  input  wire logic                   low_voltage_reset,
  input  wire logic                   clock_fail,
  input  wire logic                   watchdog_timeout,
  output logic      [15:0]            vector_addr,
  output logic                        maskable_request,
  output logic                        nonmaskable_request,
  output logic                        reset_request,
  output logic                        irq
);
  localparam int SLOTS = `SLOT_COUNT;
  localparam logic [SLOTS-1:0] RESERVED = `RESERVED_SLOTS;
  localparam int EV = `EVENT_COUNT;

  // ==========================================================
  // Synchronised pins
  logic pin_reset_n_sync;
  logic nonmask_sync;

  bit_sync #(
    .WIDTH (2),
    .INIT  (2'h2)
  ) u_pin_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({reset_pin_n, nonmaskable_request_pin}),
    .sync_out ({pin_reset_n_sync, nonmask_sync})
  );

  // ==========================================================
  // Registers
  logic [31:0]            enable_lo_reg;
  logic [SLOTS-33:0]      enable_hi_reg;
  logic [7:0]             raise_reg;
  logic [4:0]             reset_ctrl_reg;
  logic [4:0]             reset_cause_reg;
  logic [4:0]             reset_cause_next;
  logic [EV-1:0]          int_status_reg;
  logic [EV-1:0]          int_status_next;
  logic [EV-1:0]          int_mask_reg;
  logic [31:0]            rdata_next;
  vector_map_pkg::reset_state_type state_reg;
  vector_map_pkg::reset_class_type class_reg;
  logic [15:0]            hold_count_reg;

  // Start-up state is forced both by the pin reset and by every reset this
  // block raises itself; memory elsewhere is deliberately left alone.
  logic soft_clear;
  assign soft_clear = !reset_n || (state_reg == vector_map_pkg::st_hold);

  logic wr_hit_lo;
  logic wr_hit_hi;
  logic wr_hit_raise;
  logic wr_hit_ctrl;
  logic wr_hit_cause;
  logic wr_hit_mask;
  logic rd_hit_status;
  assign wr_hit_lo     = wr_strobe && (addr == `OFF_ENABLE_LO);
  assign wr_hit_hi     = wr_strobe && (addr == `OFF_ENABLE_HI);
  assign wr_hit_raise  = wr_strobe && (addr == `OFF_RAISE);
  assign wr_hit_ctrl   = wr_strobe && (addr == `OFF_RESET_CTRL);
  assign wr_hit_cause  = wr_strobe && (addr == `OFF_RESET_CAUSE);
  assign wr_hit_mask   = wr_strobe && (addr == `OFF_INT_MASK);
  assign rd_hit_status = rd_strobe && (addr == `OFF_INT_STATUS);

  always_ff @(posedge clk) begin
    if (soft_clear) begin
      enable_lo_reg <= 32'h0000_0000;
      enable_hi_reg <= '0;
    end else begin
      if (wr_hit_lo) begin
        enable_lo_reg <= wdata;
      end
      if (wr_hit_hi) begin
        enable_hi_reg <= wdata[SLOTS-33:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (soft_clear) begin
      raise_reg <= 8'h00;
    end else if (wr_hit_raise) begin
      raise_reg <= wdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (soft_clear) begin
      reset_ctrl_reg <= 5'h00;
    end else if (wr_hit_ctrl) begin
      reset_ctrl_reg <= wdata[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (soft_clear) begin
      int_mask_reg <= '0;
    end else if (wr_hit_mask) begin
      int_mask_reg <= wdata[EV-1:0];
    end
  end

  // ==========================================================
  // Reset causes
  logic monitor_on;
  logic rate_on;
  logic lvl1_cause;
  logic lvl2_cause;
  logic lvl3_cause;
  assign monitor_on = reset_ctrl_reg[`CTRL_MON_EN_BIT] || reset_ctrl_reg[`CTRL_FORCE_BIT];
  assign rate_on    = reset_ctrl_reg[`CTRL_RATE_MSB:`CTRL_RATE_LSB] != 3'h0;
  assign lvl1_cause = power_on_event || !pin_reset_n_sync || low_voltage_reset;
  assign lvl2_cause = clock_fail && monitor_on;
  assign lvl3_cause = watchdog_timeout && rate_on;

  // The cause record survives the block's own resets, otherwise software
  // could never tell the three shared-vector causes apart.
  always_comb begin
    reset_cause_next = reset_cause_reg;
    if (wr_hit_cause) begin
      reset_cause_next = reset_cause_reg & ~wdata[4:0];
    end
    if (state_reg == vector_map_pkg::st_run) begin
      reset_cause_next[`CAUSE_POWER_BIT] = reset_cause_next[`CAUSE_POWER_BIT] | power_on_event;
      reset_cause_next[`CAUSE_PIN_BIT]   = reset_cause_next[`CAUSE_PIN_BIT] | !pin_reset_n_sync;
      reset_cause_next[`CAUSE_LOWV_BIT]  = reset_cause_next[`CAUSE_LOWV_BIT] | low_voltage_reset;
      reset_cause_next[`CAUSE_CLOCK_BIT] = reset_cause_next[`CAUSE_CLOCK_BIT] | lvl2_cause;
      reset_cause_next[`CAUSE_WDOG_BIT]  = reset_cause_next[`CAUSE_WDOG_BIT] | lvl3_cause;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reset_cause_reg <= 5'h00;
    end else begin
      reset_cause_reg <= reset_cause_next;
    end
  end

  // ==========================================================
  // Reset sequencer
  logic                             any_cause;
  vector_map_pkg::reset_class_type  class_pick;
  assign any_cause = lvl1_cause || lvl2_cause || lvl3_cause;

  always_comb begin
    if (lvl1_cause) begin
      class_pick = vector_map_pkg::class_power;
    end else if (lvl2_cause) begin
      class_pick = vector_map_pkg::class_clock;
    end else if (lvl3_cause) begin
      class_pick = vector_map_pkg::class_wdog;
    end else begin
      class_pick = vector_map_pkg::class_none;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg      <= vector_map_pkg::st_run;
      class_reg      <= vector_map_pkg::class_none;
      hold_count_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        vector_map_pkg::st_run: begin
          if (any_cause) begin
            state_reg      <= vector_map_pkg::st_hold;
            class_reg      <= class_pick;
            hold_count_reg <= 16'(HOLD_CYCLES - 1);
          end
        end
        vector_map_pkg::st_hold: begin
          // A higher class arriving during the hold takes over the vector.
          if (any_cause && (class_pick < class_reg)) begin
            class_reg <= class_pick;
          end
          if (hold_count_reg == 16'h0000) begin
            state_reg <= vector_map_pkg::st_run;
          end else begin
            hold_count_reg <= hold_count_reg - 16'h0001;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Maskable selection
  logic [SLOTS-1:0] local_enable;
  logic [SLOTS-1:0] pending;
  logic             top_found;
  logic [5:0]       top_index;
  logic [5:0]       raise_index;
  logic             raise_hit;
  logic [5:0]       win_index;
  logic [7:0]       win_low;
  logic             nonmask_live;

  assign local_enable = {enable_hi_reg, enable_lo_reg};
  assign pending      = req_in & local_enable & ~RESERVED & {SLOTS{!i_mask}};
  assign nonmask_live = nonmask_sync && !x_mask;

  top_select #(
    .N  (SLOTS),
    .IW (6)
  ) u_top_select (
    .req   (pending),
    .found (top_found),
    .index (top_index)
  );

  // The raise code equals the vector low byte, so its slot is recovered
  // directly; a code naming an idle or reserved slot is simply ignored.
  assign raise_index = raise_reg[6:1];
  assign raise_hit   = raise_reg[7] && !raise_reg[0] && (raise_index < 6'(SLOTS)) &&
                       pending[raise_index];
  assign win_index   = raise_hit ? raise_index : top_index;
  assign win_low     = `VEC_SLOT_BASE + {1'b0, win_index, 1'b0};

  // ==========================================================
  // Vector outputs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      vector_addr         <= `VEC_POWER;
      maskable_request    <= 1'b0;
      nonmaskable_request <= 1'b0;
      reset_request       <= 1'b1;
    end else if (state_reg == vector_map_pkg::st_hold) begin
      reset_request       <= 1'b1;
      maskable_request    <= 1'b0;
      nonmaskable_request <= 1'b0;
      unique case (class_reg)
        vector_map_pkg::class_clock: vector_addr <= `VEC_CLOCK;
        vector_map_pkg::class_wdog:  vector_addr <= `VEC_WDOG;
        default:                     vector_addr <= `VEC_POWER;
      endcase
    end else begin
      reset_request       <= 1'b0;
      nonmaskable_request <= nonmask_live;
      maskable_request    <= top_found && !nonmask_live;
      if (nonmask_live) begin
        vector_addr <= `VEC_NONMASK;
      end else if (top_found) begin
        vector_addr <= {`VEC_PAGE, win_low};
      end else begin
        vector_addr <= 16'h0000;
      end
    end
  end

  // ==========================================================
  // Event status and interrupt
  logic [EV-1:0] events;
  always_comb begin
    events                    = '0;
    events[`EVT_RESERVED_BIT] = |(req_in & RESERVED);
    events[`EVT_WARNING_BIT]  = req_in[`SLOT_WARNING] && local_enable[`SLOT_WARNING];
    events[`EVT_CLKBLOCK_BIT] = clock_fail && !monitor_on;
    events[`EVT_NONMASK_BIT]  = nonmask_live;
    // Set wins over the read that clears in the same cycle.
    int_status_next = (rd_hit_status ? '0 : int_status_reg) | events;
  end

  always_ff @(posedge clk) begin
    if (soft_clear) begin
      int_status_reg <= '0;
    end else begin
      int_status_reg <= int_status_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status_next & int_mask_reg);
    end
  end

  // ==========================================================
  // Register read port
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (addr)
      `OFF_ENABLE_LO:   rdata_next = enable_lo_reg;
      `OFF_ENABLE_HI:   rdata_next[SLOTS-33:0] = enable_hi_reg;
      `OFF_RAISE:       rdata_next[7:0] = raise_reg;
      `OFF_RESET_CTRL:  rdata_next[4:0] = reset_ctrl_reg;
      `OFF_RESET_CAUSE: rdata_next[4:0] = reset_cause_reg;
      `OFF_INT_STATUS:  rdata_next[EV-1:0] = int_status_reg;
      `OFF_INT_MASK:    rdata_next[EV-1:0] = int_mask_reg;
      `OFF_CURRENT:     rdata_next[18:0] = {reset_request, maskable_request,
                                            nonmaskable_request, vector_addr};
      default:          rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe and are zero elsewhere.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd_strobe) begin
      rdata <= rdata_next;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
endmodule

// *** verification/vector_map_monitor.sv ***
// Concurrent checks on the vector map top-level ports.
// Assumes binding to vector_priority_map with one clock and a sync reset.
`timescale 1ns/1ns
`include "vector_map_defs.svh"
module vector_map_monitor (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        i_mask,
  input wire logic        power_on_event,
  input wire logic        low_voltage_reset,
  input wire logic        clock_fail,
  input wire logic        watchdog_timeout,
  input wire logic [15:0] vector_addr,
  input wire logic        maskable_request,
  input wire logic        nonmaskable_request,
  input wire logic        reset_request
);
  // ==========================================================
  // Helpers
  logic [63:0] resv;
  logic [6:0]  slot;
  assign resv = 64'(`RESERVED_SLOTS);
  assign slot = vector_addr[7:1] - 7'h40;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Assertions
  mask_gate_a: assert property (i_mask |=> !maskable_request)
    else $error("maskable request while i mask set");
  nonmask_vec_a: assert property (
    nonmaskable_request |-> vector_addr == `VEC_NONMASK && !maskable_request)
    else $error("nonmaskable request without its vector");
  reset_excl_a: assert property (
    reset_request |-> !maskable_request && !nonmaskable_request)
    else $error("interrupt presented during reset");
  reset_vec_a: assert property (
    reset_request |-> vector_addr inside {`VEC_POWER, `VEC_CLOCK, `VEC_WDOG})
    else $error("reset with a non reset vector");
  power_vec_a: assert property (
    power_on_event || low_voltage_reset |-> ##2 reset_request && vector_addr == `VEC_POWER)
    else $error("level one reset not taken");
  clock_vec_a: assert property (
    $rose(reset_request) && vector_addr == `VEC_CLOCK |-> $past(clock_fail, 2))
    else $error("clock reset without clock failure");
  wdog_vec_a: assert property (
    $rose(reset_request) && vector_addr == `VEC_WDOG |-> $past(watchdog_timeout, 2))
    else $error("watchdog reset without timeout");
  slot_valid_a: assert property (
    maskable_request |-> vector_addr[15:8] == 8'hff && !vector_addr[0] && !resv[slot])
    else $error("maskable vector on a reserved slot");
endmodule

bind vector_priority_map vector_map_monitor vector_map_monitor_i (
  .clk(clk), .reset_n(reset_n), .i_mask(i_mask), .power_on_event(power_on_event),
  .low_voltage_reset(low_voltage_reset), .clock_fail(clock_fail),
  .watchdog_timeout(watchdog_timeout), .vector_addr(vector_addr),
  .maskable_request(maskable_request), .nonmaskable_request(nonmaskable_request),
  .reset_request(reset_request));

// *** verification/request_source_model.sv ***
// Peripheral flags that drive the request inputs of the vector map.
// Assumes bench commands on clk; the core acknowledges the fetched vector.
`timescale 1ns/1ns
module request_source_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [57:0] raise,
  input  wire logic [57:0] drop,
  input  wire logic        ack,
  input  wire logic [15:0] vector_addr,
  output logic      [57:0] req_in
);
  // A flag stays up until its own vector is serviced or drop clears it, so a lost request
  // would show as a missing vector rather than pass unnoticed.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      req_in <= 58'h0;
    end else begin
      req_in <= (req_in | raise) & ~drop;
      if (ack && vector_addr[15:7] == 9'h1ff) begin
        req_in[vector_addr[6:1]] <= 1'b0;
      end
    end
  end
endmodule

// *** verification/vector_priority_map_tb_top.sv ***
// Self-checking bench for the vector map with a peripheral flag model.
// Assumes the design files and vector_map_defs.svh on the include path.
`timescale 1ns/1ns
module vector_priority_map_tb_top;
  // ==========================================================
  // Signals
  localparam int          HOLD = 4;
  localparam logic [57:0] ALL  = {58{1'b1}};
  typedef struct packed {
    logic [57:0] req;
    logic [57:0] en;
    logic        im;
    logic [15:0] vec;
  } row_type;
  typedef struct packed {
    logic [3:0]  ev;
    logic [31:0] ctrl;
    logic [15:0] vec;
    logic [4:0]  cause;
  } rst_row_type;
  row_type     rows [9];
  rst_row_type rrows [8];
  logic        clk = 1'b0, reset_n = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0;
  logic        i_mask = 1'b0, x_mask = 1'b0, nonmaskable_request_pin = 1'b0;
  logic        reset_pin_n = 1'b1, power_on_event = 1'b0, low_voltage_reset = 1'b0;
  logic        clock_fail = 1'b0, watchdog_timeout = 1'b0, ack = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [57:0] raise = 58'h0, drop = 58'h0, req_in;
  logic [15:0] vector_addr;
  logic        maskable_request, nonmaskable_request, reset_request, irq;
  int          n_fail = 0;
  int          total_checks = 0;

  vector_priority_map #(.HOLD_CYCLES(HOLD)) vector_priority_map_i (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rdata(rdata), .req_in(req_in), .i_mask(i_mask), .x_mask(x_mask),
    .nonmaskable_request_pin(nonmaskable_request_pin), .reset_pin_n(reset_pin_n),
    .power_on_event(power_on_event), .low_voltage_reset(low_voltage_reset),
    .clock_fail(clock_fail), .watchdog_timeout(watchdog_timeout), .vector_addr(vector_addr),
    .maskable_request(maskable_request), .nonmaskable_request(nonmaskable_request),
    .reset_request(reset_request), .irq(irq));
  request_source_model request_source_model_i (
    .clk(clk), .reset_n(reset_n), .raise(raise), .drop(drop), .ack(ack),
    .vector_addr(vector_addr), .req_in(req_in));

  always #5 clk = ~clk;

  // ==========================================================
  // Tasks
  function automatic logic [57:0] b(input int s);
    return 58'h1 << s;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Two edges of reset suffice, since the pin synchroniser loads its idle level on the first.
  // Called right after a rising edge, or at time zero.
  task automatic do_reset();
    reset_n <= 1'b0;
    wait_cyc(1);
    chk("reset_request", 32'h1, reset_request);
    chk("reset_vector", 32'hfffe, vector_addr);
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(8'h00);
    chk("enable_lo", 32'h0, d);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    test_done();
  end

  // ==========================================================
  // Sequence
  initial begin
    rows = '{'{b(55) | b(48), ALL, 1'b0, 16'hffee}, '{b(48) | b(46), ALL, 1'b0, 16'hffe0},
             '{b(46) | b(45), ALL, 1'b0, 16'hffdc}, '{b(45) | b(5), ALL, 1'b0, 16'hffda},
             '{b(5), ALL, 1'b0, 16'hff8a}, '{b(55), ALL & ~b(55), 1'b0, 16'h0},
             '{b(55), ALL, 1'b1, 16'h0}, '{b(0), ALL, 1'b0, 16'h0},
             '{b(0) | b(5), ALL, 1'b0, 16'hff8a}};
    rrows = '{'{4'h4, 32'h1, 16'hfffc, 5'h08}, '{4'h8, 32'h4, 16'hfffa, 5'h10},
              '{4'h5, 32'h1, 16'hfffe, 5'h01}, '{4'ha, 32'h4, 16'hfffe, 5'h04},
              '{4'h4, 32'h0, 16'h0, 5'h00}, '{4'h8, 32'h1, 16'h0, 5'h00},
              '{4'hc, 32'h5, 16'hfffc, 5'h08}, '{4'h4, 32'h2, 16'hfffc, 5'h08}};
    do_reset();
    $display("reset test done");
    foreach (rows[k]) begin
      wr(8'h00, rows[k].en[31:0]);
      wr(8'h04, {6'h0, rows[k].en[57:32]});
      @(posedge clk);
      i_mask <= rows[k].im;
      drop <= ALL;
      @(posedge clk);
      drop <= 58'h0;
      raise <= rows[k].req;
      @(posedge clk);
      raise <= 58'h0;
      wait_cyc(1);
      chk("vector", rows[k].vec, vector_addr);
      chk("maskable", rows[k].vec != 16'h0, maskable_request);
    end
    $display("table test done");
    @(posedge clk);
    raise <= b(55) | b(48) | b(46);
    wait_cyc(2);
    chk("vector", 32'hffee, vector_addr);
    rd(8'h1c);
    chk("current", 32'h2ffee, d);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    raise <= b(5);
    wait_cyc(1);
    chk("vector", 32'hffe0, vector_addr);
    wr(8'h08, 32'h8a);
    wait_cyc(1);
    chk("vector", 32'hff8a, vector_addr);
    wr(8'h08, 32'h0);
    @(posedge clk);
    nonmaskable_request_pin <= 1'b1;
    wait_cyc(5);
    chk("vector", 32'hfff4, vector_addr);
    chk("nonmaskable", 32'h1, nonmaskable_request);
    @(posedge clk);
    x_mask <= 1'b1;
    wait_cyc(2);
    chk("nonmaskable", 32'h0, nonmaskable_request);
    chk("vector", 32'hffe0, vector_addr);
    @(posedge clk);
    nonmaskable_request_pin <= 1'b0;
    x_mask <= 1'b0;
    drop <= ALL;
    rd(8'h14);
    chk("status", 32'hb, d);
    wr(8'h18, 32'h1);
    @(posedge clk);
    drop <= 58'h0;
    raise <= b(0);
    @(posedge clk);
    raise <= 58'h0;
    wait_cyc(4);
    chk("irq", 32'h1, irq);
    @(posedge clk);
    drop <= b(0);
    wait_cyc(2);
    rd(8'h14);
    chk("status_reserved", 32'h9, d);
    wait_cyc(2);
    chk("irq", 32'h0, irq);
    rd(8'h40);
    chk("unmapped", 32'h0, d);
    $display("interrupt test done");
    foreach (rrows[k]) begin
      wr(8'h10, 32'h1f);
      wr(8'h00, 32'hffffffff);
      wr(8'h0c, rrows[k].ctrl);
      @(posedge clk);
      {watchdog_timeout, clock_fail, low_voltage_reset, power_on_event} <= rrows[k].ev;
      @(posedge clk);
      {watchdog_timeout, clock_fail, low_voltage_reset, power_on_event} <= 4'h0;
      wait_cyc(2);
      chk("reset_request", rrows[k].vec != 16'h0, reset_request);
      chk("reset_vector", rrows[k].vec, vector_addr);
      wait_cyc(HOLD);
      chk("hold_end", 32'h0, reset_request);
      rd(8'h10);
      chk("cause", rrows[k].cause, d[4:0] & (rrows[k].cause | {5{rrows[k].cause == 5'h0}}));
      rd(8'h00);
      chk("enable_lo", rrows[k].vec != 16'h0 ? 32'h0 : 32'hffffffff, d);
    end
    wr(8'h10, 32'h1f);
    @(posedge clk);
    reset_pin_n <= 1'b0;
    @(posedge clk);
    reset_pin_n <= 1'b1;
    wait_cyc(12);
    rd(8'h10);
    chk("cause_pin", 32'h2, d & 32'h2);
    $display("reset cause test done");
    wr(8'h00, 32'hffffffff);
    do_reset();
    $display("second reset test done");
    test_done();
  end
endmodule
